/* hw/ppfm_pin_mux.sv */
`timescale 1ns/1ns
`include "ppfm_consts.svh"

module ppfm_pin_mux
    import ppfm_pkg::*;
#(
    parameter int TURN_CYC = `PPFM_TURN_CYC
) (
    input  wire logic                       CLK_IN,             // 20 MHz system clock
    input  wire logic                       ARST_N_IN,          // Master reset, active low
    input  wire logic                       PORT_MODE_BIT0_IN,  // Mode bit 0 from config_reg_zero
    input  wire logic                       PORT_MODE_BIT1_IN,  // Mode bit 1 from config_reg_zero
    input  wire logic                       PORT_MODE_BIT2_IN,  // Mode bit 2 from config_reg_nine
    input  wire logic                       AUTO_DETECT_EN_IN,  // Printer auto detect enable
    input  wire logic                       PRINTER_DETECT_IN,  // Detect pin, async
    input  wire ppfm_prn_ctl_t              PRN_CTL_IN,         // Printer engine controls
    input  wire logic [`PPFM_DATA_W-1:0]    PRN_DATA_IN,        // Printer engine data out
    input  wire logic [`PPFM_DATA_W-1:0]    PRN_DATA_OE_IN,     // Printer engine data enables
    input  wire ppfm_fdd_ctl_t              FDD_CTL_IN,         // Main floppy outputs
    output ppfm_prn_sts_t                   PRN_STS_OUT,        // Status to printer engine
    output logic [`PPFM_DATA_W-1:0]         PRN_DATA_OUT,       // Data bus to printer engine
    output ppfm_fdd_sts_t                   FDD_STS_OUT,        // External drive status
    output ppfm_role_t                      ROLE_OUT,           // Active pin role
    input  wire logic [`PPFM_STS_W-1:0]     STS_PIN_IN,         // Status pins, level
    output logic [`PPFM_STS_W-1:0]          STS_PIN_OUT,        // Status pins, drive value
    output logic [`PPFM_STS_W-1:0]          STS_PIN_OE_OUT,     // Status pins, enable
    input  wire logic [`PPFM_CTL_W-1:0]     CTL_PIN_IN,         // Control pins, level (unused)
    output logic [`PPFM_CTL_W-1:0]          CTL_PIN_OUT,        // Control pins, drive value
    output logic [`PPFM_CTL_W-1:0]          CTL_PIN_OE_OUT,     // Control pins, enable
    input  wire logic [`PPFM_DATA_W-1:0]    DATA_PIN_IN,        // Data pins, level
    output logic [`PPFM_DATA_W-1:0]         DATA_PIN_OUT,       // Data pins, drive value
    output logic [`PPFM_DATA_W-1:0]         DATA_PIN_OE_OUT     // Data pins, enable
);

    logic [2:0]                 mode;
    logic [`PPFM_SYNC_W-1:0]    sync_q;
    logic                       det_s;
    logic [`PPFM_STS_W-1:0]     sts_s;
    logic [`PPFM_DATA_W-1:0]    data_s;
    ppfm_role_t                 role;
    ppfm_role_t                 next_role;
    ppfm_state_t                state;
    logic [7:0]                 turn_cnt;
    logic [`PPFM_STS_W-1:0]     next_sts_out;
    logic [`PPFM_STS_W-1:0]     next_sts_oe;
    logic [`PPFM_CTL_W-1:0]     next_ctl_oe;
    logic [`PPFM_DATA_W-1:0]    next_data_out;
    logic [`PPFM_DATA_W-1:0]    next_data_oe;
    logic [`PPFM_STS_W-1:0]     fdd_od;
    logic [`PPFM_CTL_W-1:0]     fdd_ctl_od;
    logic [`PPFM_CTL_W-1:0]     prn_ctl_od;

    assign mode = {PORT_MODE_BIT2_IN, PORT_MODE_BIT1_IN, PORT_MODE_BIT0_IN};

    // Pins and the detect input come from outside the clock domain
    ppfm_sync #(
        .WIDTH (`PPFM_SYNC_W)
    ) u_sync (
        .clk_in    (CLK_IN),
        .arst_n_in (ARST_N_IN),
        .d_in      ({PRINTER_DETECT_IN, STS_PIN_IN, DATA_PIN_IN}),
        .q_out     (sync_q)
    );

    assign {det_s, sts_s, data_s} = sync_q;

    // Role decode from the mode bits and the detect pin
    always_comb
    begin
        if (AUTO_DETECT_EN_IN && det_s)
            next_role = ROLE_PRN;
        else if (AUTO_DETECT_EN_IN && mode == `PPFM_MODE_FDD2)
            next_role = ROLE_FDD2;
        else if (AUTO_DETECT_EN_IN)
            next_role = ROLE_FDD1;
        else if (mode == `PPFM_MODE_FDD1)
            next_role = ROLE_FDD1;
        else if (mode == `PPFM_MODE_FDD2)
            next_role = ROLE_FDD2;
        else if (mode == `PPFM_MODE_JOY)
            next_role = ROLE_JOY;
        else
            next_role = ROLE_PRN;
    end

    // Role tracking with a float window; every change restarts it
    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            role     <= ROLE_PRN;
            state    <= ST_TURN;
            turn_cnt <= `PPFM_CNT_ZERO;
        end
        else if (next_role != role)
        begin
            role     <= next_role;
            state    <= ST_TURN;
            turn_cnt <= 8'(TURN_CYC - 1);
        end
        else
        begin
            case (state)
                ST_TURN:
                begin
                    if (turn_cnt == `PPFM_CNT_ZERO)
                        state <= ST_RUN;
                    else
                        turn_cnt <= turn_cnt - `PPFM_CNT_ONE;
                end
                default:
                begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Open-drain: enable asserted means the pin is pulled low
    assign fdd_od[`PPFM_STS_BUSY] = ~FDD_CTL_IN.main_motor_on_b_n;
    assign fdd_od[`PPFM_STS_ACK]  = ~FDD_CTL_IN.main_drive_select_b_n;
    assign fdd_od[`PPFM_STS_PE]   = ~FDD_CTL_IN.main_write_data_n;
    assign fdd_od[`PPFM_STS_SLCT] = ~FDD_CTL_IN.main_write_enable_n;
    assign fdd_od[`PPFM_STS_ERR]  = ~FDD_CTL_IN.main_head_select_n;

    assign fdd_ctl_od[`PPFM_CTL_STB]  = 1'b0;
    assign fdd_ctl_od[`PPFM_CTL_AFD]  = ~FDD_CTL_IN.main_reduced_write_current_n;
    assign fdd_ctl_od[`PPFM_CTL_INIT] = ~FDD_CTL_IN.main_direction_n;
    assign fdd_ctl_od[`PPFM_CTL_SLIN] = ~FDD_CTL_IN.main_step_n;

    assign prn_ctl_od[`PPFM_CTL_STB]  = ~PRN_CTL_IN.strobe_n;
    assign prn_ctl_od[`PPFM_CTL_AFD]  = ~PRN_CTL_IN.autofd_n;
    assign prn_ctl_od[`PPFM_CTL_INIT] = ~PRN_CTL_IN.init_n;
    assign prn_ctl_od[`PPFM_CTL_SLIN] = ~PRN_CTL_IN.selectin_n;

    // Pin drive for the current role
    always_comb
    begin
        next_sts_out  = `PPFM_ZERO5;
        next_sts_oe   = `PPFM_ZERO5;
        next_ctl_oe   = `PPFM_ZERO4;
        next_data_out = `PPFM_ZERO8;
        next_data_oe  = `PPFM_ZERO8;
        if (state == ST_RUN)
        begin
            case (role)
                ROLE_FDD1:
                begin
                    next_sts_oe = fdd_od;
                    next_ctl_oe = fdd_ctl_od;
                end
                ROLE_FDD2:
                begin
                    next_sts_oe = fdd_od;
                    next_ctl_oe = fdd_ctl_od;
                    next_data_oe[`PPFM_D_MOA] = ~FDD_CTL_IN.main_motor_on_a_n;
                    next_data_oe[`PPFM_D_DSA] = ~FDD_CTL_IN.main_drive_select_a_n;
                end
                default:
                begin
                    // Printer and joystick: status pins are inputs only
                    next_ctl_oe   = prn_ctl_od;
                    next_data_out = PRN_DATA_IN;
                    next_data_oe  = PRN_DATA_OE_IN;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            STS_PIN_OUT     <= `PPFM_ZERO5;
            STS_PIN_OE_OUT  <= `PPFM_ZERO5;
            CTL_PIN_OUT     <= `PPFM_ZERO4;
            CTL_PIN_OE_OUT  <= `PPFM_ZERO4;
            DATA_PIN_OUT    <= `PPFM_ZERO8;
            DATA_PIN_OE_OUT <= `PPFM_ZERO8;
            ROLE_OUT        <= ROLE_PRN;
        end
        else
        begin
            STS_PIN_OUT     <= next_sts_out;
            STS_PIN_OE_OUT  <= next_sts_oe;
            CTL_PIN_OUT     <= `PPFM_ZERO4;
            CTL_PIN_OE_OUT  <= next_ctl_oe;
            DATA_PIN_OUT    <= next_data_out;
            DATA_PIN_OE_OUT <= next_data_oe;
            ROLE_OUT        <= role;
        end
    end

    // Status back to the engines; idle values mimic the pull-ups
    always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            PRN_STS_OUT  <= `PPFM_STS_IDLE;
            FDD_STS_OUT  <= `PPFM_FDD_IDLE;
            PRN_DATA_OUT <= `PPFM_ZERO8;
        end
        else if (role == ROLE_FDD1 || role == ROLE_FDD2)
        begin
            PRN_STS_OUT  <= `PPFM_STS_IDLE;
            FDD_STS_OUT  <= data_s[`PPFM_D_FDD_MSB:0];
            PRN_DATA_OUT <= `PPFM_ZERO8;
        end
        else
        begin
            PRN_STS_OUT.busy    <= sts_s[`PPFM_STS_BUSY];
            PRN_STS_OUT.ack_n   <= sts_s[`PPFM_STS_ACK];
            PRN_STS_OUT.slct    <= sts_s[`PPFM_STS_SLCT];
            PRN_STS_OUT.error_n <= sts_s[`PPFM_STS_ERR];
            // Joystick leaves paper-end unsampled
            PRN_STS_OUT.pe      <= (role == ROLE_JOY) ? 1'b0 : sts_s[`PPFM_STS_PE];
            FDD_STS_OUT         <= `PPFM_FDD_IDLE;
            PRN_DATA_OUT        <= data_s;
        end
    end

    a_busy_ready: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        role == ROLE_PRN && next_role == ROLE_PRN |=> PRN_STS_OUT.busy == $past(sts_s[`PPFM_STS_BUSY])
    ) else $error("busy status not passed");

    a_ack_err_pass: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        role == ROLE_PRN && next_role == ROLE_PRN
        |=> {PRN_STS_OUT.ack_n, PRN_STS_OUT.error_n, PRN_STS_OUT.slct}
            == $past({sts_s[`PPFM_STS_ACK], sts_s[`PPFM_STS_ERR], sts_s[`PPFM_STS_SLCT]})
    ) else $error("ack, error or select status not passed");

    a_prn_sts_float: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        role == ROLE_PRN |=> STS_PIN_OE_OUT == `PPFM_ZERO5
    ) else $error("status pin driven in printer role");

    a_autofd_drive: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && role == ROLE_PRN
        |=> CTL_PIN_OE_OUT[`PPFM_CTL_AFD] == !$past(PRN_CTL_IN.autofd_n) && CTL_PIN_OUT == `PPFM_ZERO4
    ) else $error("auto feed drive wrong");

    a_strobe_drive: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && role == ROLE_PRN
        |=> CTL_PIN_OE_OUT[`PPFM_CTL_STB] == !$past(PRN_CTL_IN.strobe_n)
    ) else $error("strobe drive wrong");

    a_data_bus: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && role == ROLE_PRN
        |=> DATA_PIN_OUT == $past(PRN_DATA_IN) && DATA_PIN_OE_OUT == $past(PRN_DATA_OE_IN)
    ) else $error("printer data bus drive wrong");

    a_motor_b_pin: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && (role == ROLE_FDD1 || role == ROLE_FDD2)
        |=> STS_PIN_OE_OUT[`PPFM_STS_BUSY] == !$past(FDD_CTL_IN.main_motor_on_b_n)
            && STS_PIN_OE_OUT[`PPFM_STS_ERR] == !$past(FDD_CTL_IN.main_head_select_n)
    ) else $error("floppy status pin drive wrong");

    a_step_dir: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && role == ROLE_FDD1
        |=> CTL_PIN_OE_OUT[`PPFM_CTL_SLIN] == !$past(FDD_CTL_IN.main_step_n)
            && CTL_PIN_OE_OUT[`PPFM_CTL_INIT] == !$past(FDD_CTL_IN.main_direction_n)
    ) else $error("step or direction drive wrong");

    a_ext_status: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        role == ROLE_FDD1 || role == ROLE_FDD2 |=> FDD_STS_OUT == $past(data_s[`PPFM_D_FDD_MSB:0])
    ) else $error("external drive status not passed");

    a_single_float: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        role == ROLE_FDD1 |=> !CTL_PIN_OE_OUT[`PPFM_CTL_STB] && DATA_PIN_OE_OUT == `PPFM_ZERO8
    ) else $error("single floppy float pins driven");

    a_dual_drive_a: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && role == ROLE_FDD2
        |=> DATA_PIN_OE_OUT[`PPFM_D_MOA] == !$past(FDD_CTL_IN.main_motor_on_a_n)
            && DATA_PIN_OE_OUT[`PPFM_D_DSA] == !$past(FDD_CTL_IN.main_drive_select_a_n)
    ) else $error("drive A motor or select wrong");

    a_dual_float: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        role == ROLE_FDD2 |=> !CTL_PIN_OE_OUT[`PPFM_CTL_STB] && !DATA_PIN_OE_OUT[`PPFM_D_NC]
    ) else $error("dual floppy float pins driven");

    a_joy_pe_idle: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        role == ROLE_JOY |=> !PRN_STS_OUT.pe && !STS_PIN_OE_OUT[`PPFM_STS_PE]
    ) else $error("paper-end used in joystick role");

    a_auto_detect: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        AUTO_DETECT_EN_IN && mode != `PPFM_MODE_FDD2 |=> role == ($past(det_s) ? ROLE_PRN : ROLE_FDD1)
    ) else $error("auto detect role wrong");

    a_turn_float: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && next_role != role
        |=> ##1 (STS_PIN_OE_OUT == `PPFM_ZERO5 && CTL_PIN_OE_OUT == `PPFM_ZERO4
                 && DATA_PIN_OE_OUT == `PPFM_ZERO8)[*2]
    ) else $error("pins driven during turnaround");

    a_mode_dual: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        !AUTO_DETECT_EN_IN && mode == `PPFM_MODE_FDD2 |=> role == ROLE_FDD2
    ) else $error("dual floppy code not decoded");

    a_mode_joy: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        !AUTO_DETECT_EN_IN && mode == `PPFM_MODE_JOY |=> role == ROLE_JOY
    ) else $error("joystick code not decoded");

    a_pe_err_pass: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        role == ROLE_PRN && next_role == ROLE_PRN
        |=> {PRN_STS_OUT.pe, PRN_STS_OUT.error_n} == $past({sts_s[`PPFM_STS_PE], sts_s[`PPFM_STS_ERR]})
    ) else $error("paper-end or error status not passed");

    a_wd_we_pins: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && (role == ROLE_FDD1 || role == ROLE_FDD2)
        |=> STS_PIN_OE_OUT[`PPFM_STS_PE] == !$past(FDD_CTL_IN.main_write_data_n)
            && STS_PIN_OE_OUT[`PPFM_STS_SLCT] == !$past(FDD_CTL_IN.main_write_enable_n)
    ) else $error("write data or enable pin drive wrong");

    a_dual_shared: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && role == ROLE_FDD2
        |=> STS_PIN_OE_OUT[`PPFM_STS_ACK] == !$past(FDD_CTL_IN.main_drive_select_b_n)
            && CTL_PIN_OE_OUT[`PPFM_CTL_SLIN] == !$past(FDD_CTL_IN.main_step_n)
    ) else $error("shared drive pins wrong in dual mode");

    a_motor_a_low: assert property (@(posedge CLK_IN) disable iff (!ARST_N_IN)
        state == ST_RUN && role == ROLE_FDD2 && !FDD_CTL_IN.main_motor_on_a_n
        |=> DATA_PIN_OE_OUT[`PPFM_D_MOA] && !DATA_PIN_OUT[`PPFM_D_MOA]
    ) else $error("motor-on A not pulled low");

endmodule : ppfm_pin_mux

/* hw/ppfm_consts.svh */
`ifndef PPFM_CONSTS_SVH
`define PPFM_CONSTS_SVH

// Mode codes carried by the three mode bits
`define PPFM_MODE_FDD1      3'h1
`define PPFM_MODE_JOY       3'h2
`define PPFM_MODE_FDD2      3'h3

// Status pin indices (printer inputs / floppy open-drain outputs)
`define PPFM_STS_BUSY       0
`define PPFM_STS_ACK        1
`define PPFM_STS_PE         2
`define PPFM_STS_SLCT       3
`define PPFM_STS_ERR        4
`define PPFM_STS_W          5

// Control pin indices
`define PPFM_CTL_STB        0
`define PPFM_CTL_AFD        1
`define PPFM_CTL_INIT       2
`define PPFM_CTL_SLIN       3
`define PPFM_CTL_W          4

// Data pin roles in floppy modes
`define PPFM_DATA_W         8
`define PPFM_D_FDD_MSB      4
`define PPFM_D_NC           5
`define PPFM_D_MOA          6
`define PPFM_D_DSA          7

// Reset and idle values
`define PPFM_STS_IDLE       5'h1f
`define PPFM_FDD_IDLE       5'h1f
`define PPFM_ZERO5          5'h00
`define PPFM_ZERO4          4'h0
`define PPFM_ZERO8          8'h00
`define PPFM_SYNC_W         14
`define PPFM_CNT_ZERO       8'h00
`define PPFM_CNT_ONE        8'h01

// Turnaround float time on a role change
`define PPFM_CLK_NS         50
`define PPFM_TURN_NS        100
`define PPFM_TURN_CYC       ((`PPFM_TURN_NS + `PPFM_CLK_NS - 1) / `PPFM_CLK_NS)

`endif

/* hw/ppfm_pkg.sv */
package ppfm_pkg;

    typedef enum logic [3:0]
    {
        ROLE_PRN  = 4'b0001,
        ROLE_FDD1 = 4'b0010,
        ROLE_FDD2 = 4'b0100,
        ROLE_JOY  = 4'b1000
    } ppfm_role_t;

    typedef enum logic [1:0]
    {
        ST_RUN  = 2'b01,
        ST_TURN = 2'b10
    } ppfm_state_t;

    typedef struct packed
    {
        logic strobe_n;
        logic autofd_n;
        logic init_n;
        logic selectin_n;
    } ppfm_prn_ctl_t;

    typedef struct packed
    {
        logic busy;
        logic ack_n;
        logic pe;
        logic slct;
        logic error_n;
    } ppfm_prn_sts_t;

    typedef struct packed
    {
        logic main_motor_on_a_n;
        logic main_motor_on_b_n;
        logic main_drive_select_a_n;
        logic main_drive_select_b_n;
        logic main_write_data_n;
        logic main_write_enable_n;
        logic main_head_select_n;
        logic main_step_n;
        logic main_direction_n;
        logic main_reduced_write_current_n;
    } ppfm_fdd_ctl_t;

    typedef struct packed
    {
        logic ext_disk_change_in_n;
        logic ext_read_data_in_n;
        logic ext_write_protect_in_n;
        logic ext_track_zero_in_n;
        logic ext_index_in_n;
    } ppfm_fdd_sts_t;

endpackage : ppfm_pkg

/* hw/ppfm_sync.sv */
`timescale 1ns/1ns

module ppfm_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,   // System clock
    input  wire logic             arst_n_in, // Async reset
    input  wire logic [WIDTH-1:0] d_in,     // Asynchronous inputs
    output logic      [WIDTH-1:0] q_out     // Synchronised outputs
);

    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            // First stage feeds only the second stage
            always_ff @(posedge clk_in or negedge arst_n_in)
            begin
                if (!arst_n_in)
                begin
                    meta[i]  <= 1'b1;
                    q_out[i] <= 1'b1;
                end
                else
                begin
                    meta[i]  <= d_in[i];
                    q_out[i] <= meta[i];
                end
            end
        end
    endgenerate

endmodule : ppfm_sync

/* tb/ppfm_far_side.sv */
`timescale 1ns/1ns
`include "ppfm_consts.svh"

module ppfm_far_side
(
    input  wire logic [`PPFM_STS_W-1:0]  sts_o_in,     // Device value, status pins
    input  wire logic [`PPFM_STS_W-1:0]  sts_oe_in,    // Device enable, status pins
    input  wire logic [`PPFM_CTL_W-1:0]  ctl_o_in,     // Device value, control pins
    input  wire logic [`PPFM_CTL_W-1:0]  ctl_oe_in,    // Device enable, control pins
    input  wire logic [`PPFM_DATA_W-1:0] d_o_in,       // Device value, data pins
    input  wire logic [`PPFM_DATA_W-1:0] d_oe_in,      // Device enable, data pins
    input  wire logic [`PPFM_STS_W-1:0]  far_s_in,     // Far side value, status pins
    input  wire logic [`PPFM_STS_W-1:0]  far_s_oe_in,  // Far side enable, status pins
    input  wire logic [`PPFM_DATA_W-1:0] far_d_in,     // Far side value, data pins
    input  wire logic [`PPFM_DATA_W-1:0] far_d_oe_in,  // Far side enable, data pins
    output logic      [`PPFM_STS_W-1:0]  sts_lvl_out,  // Status pin levels
    output logic      [`PPFM_CTL_W-1:0]  ctl_lvl_out,  // Control pin levels
    output logic      [`PPFM_DATA_W-1:0] d_lvl_out,    // Data pin levels
    output logic      [`PPFM_DATA_W-1:0] latched_out   // Byte taken by the printer
);
    // Every pin has a pull-up, so a released pin reads 1, never a stale value
    assign sts_lvl_out = (~sts_oe_in | sts_o_in) & (~far_s_oe_in | far_s_in);
    assign ctl_lvl_out = ~ctl_oe_in | ctl_o_in;
    assign d_lvl_out   = (~d_oe_in | d_o_in) & (~far_d_oe_in | far_d_in);

    initial latched_out = 8'h00;

    // Printer takes the byte on the falling strobe
    always @(negedge ctl_lvl_out[`PPFM_CTL_STB])
        latched_out <= d_lvl_out;
endmodule : ppfm_far_side

/* tb/tb.sv */
`timescale 1ns/1ns
`include "ppfm_consts.svh"

module tb import ppfm_pkg::*;;
    logic           clk;
    logic           arst_n;
    logic [2:0]     mode;
    logic           auto_en;
    logic           det;
    ppfm_prn_ctl_t  prn_ctl;
    logic [7:0]     prn_d;
    logic [7:0]     prn_oe;
    ppfm_fdd_ctl_t  fdd_ctl;
    ppfm_prn_sts_t  prn_sts;
    logic [7:0]     prn_q;
    ppfm_fdd_sts_t  fdd_sts;
    ppfm_role_t     role;
    logic [4:0]     sts_lvl, sts_o, sts_oe, far_s, far_s_oe;
    logic [3:0]     ctl_lvl, ctl_o, ctl_oe;
    logic [7:0]     d_lvl, d_o, d_oe, far_d, far_d_oe, latched;
    int             err_total;
    int             cmp_count;

    ppfm_pin_mux #(.TURN_CYC(2)) u_dut (
        .CLK_IN(clk), .ARST_N_IN(arst_n), .PORT_MODE_BIT0_IN(mode[0]),
        .PORT_MODE_BIT1_IN(mode[1]), .PORT_MODE_BIT2_IN(mode[2]),
        .AUTO_DETECT_EN_IN(auto_en), .PRINTER_DETECT_IN(det), .PRN_CTL_IN(prn_ctl),
        .PRN_DATA_IN(prn_d), .PRN_DATA_OE_IN(prn_oe), .FDD_CTL_IN(fdd_ctl),
        .PRN_STS_OUT(prn_sts), .PRN_DATA_OUT(prn_q), .FDD_STS_OUT(fdd_sts), .ROLE_OUT(role),
        .STS_PIN_IN(sts_lvl), .STS_PIN_OUT(sts_o), .STS_PIN_OE_OUT(sts_oe),
        .CTL_PIN_IN(ctl_lvl), .CTL_PIN_OUT(ctl_o), .CTL_PIN_OE_OUT(ctl_oe),
        .DATA_PIN_IN(d_lvl), .DATA_PIN_OUT(d_o), .DATA_PIN_OE_OUT(d_oe));

    ppfm_far_side u_far (
        .sts_o_in(sts_o), .sts_oe_in(sts_oe), .ctl_o_in(ctl_o), .ctl_oe_in(ctl_oe),
        .d_o_in(d_o), .d_oe_in(d_oe), .far_s_in(far_s), .far_s_oe_in(far_s_oe),
        .far_d_in(far_d), .far_d_oe_in(far_d_oe), .sts_lvl_out(sts_lvl),
        .ctl_lvl_out(ctl_lvl), .d_lvl_out(d_lvl), .latched_out(latched));

    always #25 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    task automatic t_codes;
        logic [3:0] exp_r [8] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h1, 4'h1, 4'h1, 4'h1};
        for (int i = 0; i < 8; i++)
        begin
            mode = i[2:0];
            tick(8);
            chk("role per code", role, exp_r[i]);
        end
        mode = 3'h0;
        tick(8);
    endtask : t_codes

    task automatic t_printer;
        prn_ctl = '{strobe_n: 1'b1, autofd_n: 1'b0, init_n: 1'b1, selectin_n: 1'b0};
        prn_d = 8'ha5;
        prn_oe = 8'hff;
        tick(2);
        chk("ctl oe", ctl_oe, 4'ha);
        chk("data out", d_o, 8'ha5);
        chk("data oe", d_oe, 8'hff);
        prn_ctl.strobe_n = 1'b0;
        tick(2);
        chk("byte taken", latched, 8'ha5);
        prn_ctl.strobe_n = 1'b1;
        prn_oe = 8'h00;
        far_d = 8'h1d;
        far_d_oe = 8'hff;
        far_s = 5'b10110;
        far_s_oe = 5'h1f;
        tick(4);
        chk("data in", prn_q, 8'h1d);
        chk("busy", prn_sts.busy, 1'b0);
        chk("ack", prn_sts.ack_n, 1'b1);
        chk("pe", prn_sts.pe, 1'b1);
        chk("slct", prn_sts.slct, 1'b0);
        chk("error", prn_sts.error_n, 1'b1);
        far_s = 5'b01001;
        tick(4);
        chk("status flip", prn_sts, 5'h12);
        far_s_oe = 5'h00;
        far_d_oe = 8'h00;
        tick(4);
        chk("idle status", prn_sts, 5'h1f);
    endtask : t_printer

    task automatic t_fdd1;
        prn_ctl = '0;
        prn_oe = 8'hff;
        fdd_ctl = '1;
        {fdd_ctl.main_motor_on_b_n, fdd_ctl.main_write_data_n} = 2'b00;
        {fdd_ctl.main_head_select_n, fdd_ctl.main_step_n} = 2'b00;
        fdd_ctl.main_reduced_write_current_n = 1'b0;
        tick(2);
        chk("ctl oe prn", ctl_oe, 4'hf);
        mode = 3'h1;
        tick(2);
        chk("turn float", {sts_oe, ctl_oe, d_oe}, 17'h0);
        tick(1);
        chk("turn float", {sts_oe, ctl_oe, d_oe}, 17'h0);
        tick(3);
        chk("role", role, ROLE_FDD1);
        chk("sts oe", sts_oe, 5'b10101);
        chk("ctl oe", ctl_oe, 4'b1010);
        chk("data oe", d_oe, 8'h00);
        fdd_ctl = ~fdd_ctl;
        far_d = 8'h1a;
        far_d_oe = 8'hff;
        tick(4);
        chk("sts oe", sts_oe, 5'b01010);
        chk("ctl oe", ctl_oe, 4'b0100);
        chk("drive status", fdd_sts, 5'h1a);
        chk("prn status", prn_sts, 5'h1f);
    endtask : t_fdd1

    task automatic t_fdd2;
        mode = 3'h3;
        far_d = 8'h05;
        far_d_oe = 8'h1f;
        fdd_ctl.main_motor_on_a_n = 1'b0;
        fdd_ctl.main_drive_select_a_n = 1'b1;
        tick(8);
        chk("role", role, ROLE_FDD2);
        chk("data oe", d_oe, 8'h40);
        chk("data out", d_o[7:5], 3'h0);
        chk("sts oe", sts_oe, 5'b01010);
        chk("ctl oe", ctl_oe, 4'b0100);
        chk("drive status", fdd_sts, 5'h05);
        fdd_ctl.main_motor_on_a_n = 1'b1;
        fdd_ctl.main_drive_select_a_n = 1'b0;
        tick(2);
        chk("data oe", d_oe, 8'h80);
    endtask : t_fdd2

    task automatic t_joy;
        mode = 3'h2;
        far_d_oe = 8'h00;
        far_s = 5'b11110;
        far_s_oe = 5'h1f;
        tick(8);
        chk("role", role, ROLE_JOY);
        chk("pe unused", prn_sts.pe, 1'b0);
        chk("pe float", sts_oe[`PPFM_STS_PE], 1'b0);
        chk("busy", prn_sts.busy, 1'b0);
        far_s_oe = 5'h00;
    endtask : t_joy

    task automatic t_auto;
        auto_en = 1'b1;
        det = 1'b0;
        mode = 3'h0;
        tick(10);
        chk("detect low", role, ROLE_FDD1);
        mode = 3'h3;
        tick(10);
        chk("detect low dual", role, ROLE_FDD2);
        det = 1'b1;
        tick(10);
        chk("detect high", role, ROLE_PRN);
        auto_en = 1'b0;
    endtask : t_auto

    initial
    begin
        clk = 1'b0;
        arst_n = 1'b0;
        mode = 3'h0;
        auto_en = 1'b0;
        det = 1'b1;
        prn_ctl = '1;
        prn_d = 8'h00;
        prn_oe = 8'h00;
        fdd_ctl = '1;
        {far_s, far_s_oe, far_d, far_d_oe} = '0;
        err_total = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk);
        #1;
        chk("reset role", role, ROLE_PRN);
        chk("reset oe", {sts_oe, ctl_oe, d_oe}, 17'h0);
        chk("reset status", {prn_sts, fdd_sts}, 10'h3ff);
        tick(10);
        arst_n = 1'b1;
        tick(4);
        t_codes();
        t_printer();
        t_fdd1();
        t_fdd2();
        t_joy();
        t_auto();
        test_done();
    end

    // Whole run is under two hundred cycles
    initial
    begin
        #(50 * 4000);
        err_total++;
        test_done();
    end
endmodule : tb
